// ---- include/sts_consts.svh ----
`ifndef STS_CONSTS_SVH
`define STS_CONSTS_SVH

// Register offsets (byte addresses)
`define STS_ADDR_W        8
`define STS_OFF_CTRL      8'h04
`define STS_OFF_LEN       8'h40
`define STS_OFF_STAT      8'h44

// Control register field positions
`define STS_EN_BIT        0
`define STS_MST_BIT       1
`define STS_SSIO_BIT      4
`define STS_START_BIT     5
`define STS_SSCTRL_BIT    8
`define STS_SSACT_LSB     16
`define STS_SSACT_MSB     19

// Length register and status register fields
`define STS_LEN_MSB       5
`define STS_LEN_RST       6'h08
`define STS_STAT_BUSY     0
`define STS_STAT_HELD     1
`define STS_STAT_GAP      2
`define STS_STAT_SS_LSB   8

// Timing: clock period and least select-release gap
`define STS_CLK_NS        20
`define STS_SS_GAP_NS     100
`define STS_SS_GAP_CYC    ((`STS_SS_GAP_NS + `STS_CLK_NS - 1) / `STS_CLK_NS)

// AXI responses
`define STS_RESP_OKAY     2'h0
`define STS_RESP_DECERR   2'h3

`endif

// ---- include/sts_pkg.sv ----
`include "sts_consts.svh"
`default_nettype none

package sts_pkg;

    // Master-to-slave AXI4-Lite signals
    typedef struct packed {
        logic [`STS_ADDR_W-1:0] awaddr;
        logic                   awvalid;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   wvalid;
        logic                   bready;
        logic [`STS_ADDR_W-1:0] araddr;
        logic                   arvalid;
        logic                   rready;
    } sts_axil_req_t;

    // Slave-to-master AXI4-Lite signals
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } sts_axil_rsp_t;

    // Select sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_HELD,
        ST_GAP
    } sts_state_t;

endpackage : sts_pkg

`default_nettype wire

// ---- rtl/sts_axil_slave.sv ----
`include "sts_consts.svh"
`default_nettype none

module sts_axil_slave (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire sts_pkg::sts_axil_req_t  axi_req,
    output sts_pkg::sts_axil_rsp_t       axi_rsp,
    output logic                         wr_req,
    output logic [`STS_ADDR_W-1:0]       wr_addr,
    output logic [31:0]                  wr_data,
    output logic [3:0]                   wr_strb,
    input  wire logic                    wr_err,
    output logic [`STS_ADDR_W-1:0]       rd_addr,
    input  wire logic [31:0]             rd_data,
    input  wire logic                    rd_err
);
    import sts_pkg::*;

    logic                   aw_free_reg;
    logic                   w_free_reg;
    logic                   ar_free_reg;
    logic [`STS_ADDR_W-1:0] aw_addr_reg;
    logic [31:0]            w_data_reg;
    logic [3:0]             w_strb_reg;
    logic                   bvalid_reg;
    logic [1:0]             bresp_reg;
    logic                   rvalid_reg;
    logic [1:0]             rresp_reg;
    logic [31:0]            rdata_reg;

    // Write fires once address and data are both held and no response waits
    assign wr_req  = ~aw_free_reg & ~w_free_reg & ~bvalid_reg;
    assign wr_addr = aw_addr_reg;
    assign wr_data = w_data_reg;
    assign wr_strb = w_strb_reg;
    assign rd_addr = axi_req.araddr;

    // Write address holding stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_free_reg <= 1'b1;
            aw_addr_reg <= '0;
        end else if (axi_req.awvalid && aw_free_reg) begin
            aw_free_reg <= 1'b0;
            aw_addr_reg <= axi_req.awaddr;
        end else if (wr_req) begin
            aw_free_reg <= 1'b1;
        end
    end

    // Write data holding stage, taken independently of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_free_reg <= 1'b1;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (axi_req.wvalid && w_free_reg) begin
            w_free_reg <= 1'b0;
            w_data_reg <= axi_req.wdata;
            w_strb_reg <= axi_req.wstrb;
        end else if (wr_req) begin
            w_free_reg <= 1'b1;
        end
    end

    // Write response, unmapped addresses answer DECERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `STS_RESP_OKAY;
        end else if (wr_req) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_err ? `STS_RESP_DECERR : `STS_RESP_OKAY;
        end else if (bvalid_reg && axi_req.bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read channel: data captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_free_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= `STS_RESP_OKAY;
            rdata_reg   <= '0;
        end else if (axi_req.arvalid && ar_free_reg) begin
            ar_free_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rresp_reg   <= rd_err ? `STS_RESP_DECERR : `STS_RESP_OKAY;
            rdata_reg   <= rd_err ? 32'h0000_0000 : rd_data;
        end else if (rvalid_reg && axi_req.rready) begin
            ar_free_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    assign axi_rsp.awready = aw_free_reg;
    assign axi_rsp.wready  = w_free_reg;
    assign axi_rsp.bresp   = bresp_reg;
    assign axi_rsp.bvalid  = bvalid_reg;
    assign axi_rsp.arready = ar_free_reg;
    assign axi_rsp.rdata   = rdata_reg;
    assign axi_rsp.rresp   = rresp_reg;
    assign axi_rsp.rvalid  = rvalid_reg;

endmodule : sts_axil_slave

`default_nettype wire

// ---- rtl/sts_select_ctrl.sv ----
// Summary of operation
// - Four select outputs, chosen by mask bits 19:16 of the control register.
// - On start, exactly the mask bits captured at start assert their select lines.
// - Mask bit n drives line n; any mix of lines may assert together.
// - Hold bit 8 clear: active selects release when the transaction completes.
// - Hold bit 8 set: active selects stay asserted after the transaction completes.
// - From held selects, the next transaction starts with no release gap.
// - Writing 1 to start launches a transaction on an enabled controller; software waits for the previous.
// - Controller-mode bit 0 makes a target port, 1 a controller driving selects.
`include "sts_consts.svh"
`default_nettype none

module sts_select_ctrl (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire sts_pkg::sts_axil_req_t  axi_req,
    output sts_pkg::sts_axil_rsp_t       axi_rsp,
    input  wire logic                    link_sclk,
    output logic [3:0]                   target_select_n,
    output logic                         target_select_oe,
    output logic                         xfer_start,
    output logic                         xfer_active
);
    import sts_pkg::*;

    localparam logic [3:0] GAP_LOAD = 4'(`STS_SS_GAP_CYC - 1);

    logic                   wr_req;
    logic [`STS_ADDR_W-1:0] wr_addr;
    logic [31:0]            wr_data;
    logic [3:0]             wr_strb;
    logic [`STS_ADDR_W-1:0] rd_addr;
    logic [31:0]            rd_data;
    logic                   en_reg;
    logic                   mst_reg;
    logic                   ssio_reg;
    logic                   hold_reg;
    logic [3:0]             mask_reg;
    logic [5:0]             len_reg;
    logic                   en_next;
    logic                   mst_next;
    logic                   hold_next;
    logic [3:0]             mask_next;
    logic                   ssio_next;
    logic                   wr_ctrl;
    logic                   start_go;
    sts_state_t             state_reg;
    sts_state_t             state_next;
    logic [3:0]             sel_reg;
    logic [3:0]             sel_next;
    logic [5:0]             bit_cnt_reg;
    logic [3:0]             gap_cnt_reg;
    logic                   sclk_s1_reg;
    logic                   sclk_s2_reg;
    logic                   sclk_s3_reg;
    logic                   sclk_rise;
    logic                   last_bit;
    logic                   run_ok;

    // Address decode, shared by the write and read paths
    function automatic logic addr_mapped(input logic [`STS_ADDR_W-1:0] a);
        return (a == `STS_OFF_CTRL) || (a == `STS_OFF_LEN) || (a == `STS_OFF_STAT);
    endfunction : addr_mapped

    sts_axil_slave u_slave (
        .aclk    (aclk),
        .aresetn (aresetn),
        .axi_req (axi_req),
        .axi_rsp (axi_rsp),
        .wr_req  (wr_req),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_err  (~addr_mapped(wr_addr)),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_err  (~addr_mapped(rd_addr))
    );

    // Control register after a write, byte lanes honoured
    assign wr_ctrl   = wr_req && (wr_addr == `STS_OFF_CTRL);
    assign en_next   = (wr_ctrl && wr_strb[0]) ? wr_data[`STS_EN_BIT] : en_reg;
    assign mst_next  = (wr_ctrl && wr_strb[0]) ? wr_data[`STS_MST_BIT] : mst_reg;
    assign hold_next = (wr_ctrl && wr_strb[1]) ? wr_data[`STS_SSCTRL_BIT] : hold_reg;
    assign ssio_next = (wr_ctrl && wr_strb[0]) ? wr_data[`STS_SSIO_BIT] : ssio_reg;
    assign mask_next = (wr_ctrl && wr_strb[2]) ?
                       wr_data[`STS_SSACT_MSB:`STS_SSACT_LSB] : mask_reg;

    // Start only acts as a write of 1 on an enabled controller; a 0 is ignored.
    // A start that lands mid-transaction is dropped, software must wait.
    assign start_go = wr_ctrl && wr_strb[0] && wr_data[`STS_START_BIT] &&
                      en_next && mst_next &&
                      (state_reg == ST_IDLE || state_reg == ST_HELD);

    // Control fields; reserved bits have no storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_reg   <= 1'b0;
            mst_reg  <= 1'b0;
            ssio_reg <= 1'b0;
            hold_reg <= 1'b0;
            mask_reg <= 4'h0;
        end else if (wr_ctrl) begin
            en_reg   <= en_next;
            mst_reg  <= mst_next;
            hold_reg <= hold_next;
            mask_reg <= mask_next;
            ssio_reg <= ssio_next;
        end
    end

    // Transaction length in link clock rising edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            len_reg <= `STS_LEN_RST;
        end else if (wr_req && wr_addr == `STS_OFF_LEN && wr_strb[0]) begin
            len_reg <= wr_data[`STS_LEN_MSB:0];
        end
    end

    // Read mux; unused and reserved bits read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        case (rd_addr)
            `STS_OFF_CTRL: begin
                rd_data[`STS_EN_BIT]                     = en_reg;
                rd_data[`STS_MST_BIT]                    = mst_reg;
                rd_data[`STS_SSIO_BIT]                   = ssio_reg;
                rd_data[`STS_START_BIT]                  = (state_reg == ST_ACTIVE);
                rd_data[`STS_SSCTRL_BIT]                 = hold_reg;
                rd_data[`STS_SSACT_MSB:`STS_SSACT_LSB]   = mask_reg;
            end
            `STS_OFF_LEN: begin
                rd_data[`STS_LEN_MSB:0] = len_reg;
            end
            `STS_OFF_STAT: begin
                rd_data[`STS_STAT_BUSY]                    = (state_reg == ST_ACTIVE);
                rd_data[`STS_STAT_HELD]                    = (state_reg == ST_HELD);
                rd_data[`STS_STAT_GAP]                     = (state_reg == ST_GAP);
                rd_data[`STS_STAT_SS_LSB+3:`STS_STAT_SS_LSB] = sel_reg;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // Link clock arrives from outside: two flops, then a third for the edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_s3_reg <= 1'b0;
        end else begin
            sclk_s1_reg <= link_sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
        end
    end

    assign sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
    assign last_bit  = ({1'b0, bit_cnt_reg} + 7'h01) >= {1'b0, len_reg};
    assign run_ok    = en_reg & mst_reg;

    // Sequencer: selects follow the mask captured at start
    always_comb begin
        state_next = state_reg;
        sel_next   = sel_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_go) begin
                    state_next = ST_ACTIVE;
                    sel_next   = mask_next;
                end
            end
            ST_ACTIVE: begin
                if (!run_ok) begin
                    state_next = ST_GAP;
                    sel_next   = 4'h0;
                end else if (sclk_rise && last_bit) begin
                    if (hold_reg) begin
                        state_next = ST_HELD;
                    end else begin
                        state_next = ST_GAP;
                        sel_next   = 4'h0;
                    end
                end
            end
            ST_HELD: begin
                if (start_go) begin
                    state_next = ST_ACTIVE;
                    sel_next   = mask_next;
                end else if (!hold_next || !run_ok) begin
                    state_next = ST_GAP;
                    sel_next   = 4'h0;
                end
            end
            ST_GAP: begin
                // The release gap keeps the target's deselect time honest
                if (gap_cnt_reg == 4'h0) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                sel_next   = 4'h0;
            end
        endcase
    end

    // State, active mask and release gap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg   <= ST_IDLE;
            sel_reg     <= 4'h0;
            gap_cnt_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            sel_reg   <= sel_next;
            if (state_next == ST_GAP && state_reg != ST_GAP) begin
                gap_cnt_reg <= GAP_LOAD;
            end else if (gap_cnt_reg != 4'h0) begin
                gap_cnt_reg <= gap_cnt_reg - 4'h1;
            end
        end
    end

    // Bits seen in the current transaction
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bit_cnt_reg <= 6'h00;
        end else if (state_next == ST_ACTIVE && state_reg != ST_ACTIVE) begin
            bit_cnt_reg <= 6'h00;
        end else if (state_reg == ST_ACTIVE && sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
        end
    end

    // Pins: selects active low, driven only as an output-mode controller
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            target_select_n  <= 4'hf;
            target_select_oe <= 1'b0;
            xfer_start       <= 1'b0;
            xfer_active      <= 1'b0;
        end else begin
            target_select_n  <= ~sel_next;
            // Next value of direction too, so one write never glitches the enable
            target_select_oe <= en_next & mst_next & ~ssio_next;
            xfer_start       <= start_go;
            xfer_active      <= (state_next == ST_ACTIVE);
        end
    end

endmodule : sts_select_ctrl

`default_nettype wire

// ---- test/sts_select_ctrl_checker.sv ----
`include "sts_consts.svh"
`default_nettype none

module sts_sel_checker (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire sts_pkg::sts_axil_req_t axi_req,
    input wire sts_pkg::sts_axil_rsp_t axi_rsp,
    input wire logic                   link_sclk,
    input wire logic [3:0]             target_select_n,
    input wire logic                   target_select_oe,
    input wire logic                   xfer_start,
    input wire logic                   xfer_active
);
    import sts_pkg::*;

    // One domain, so clock and reset are given once
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Launch and select relations
    start_active_a: assert property (xfer_start |-> xfer_active)
        else $error("start pulse without active transfer");
    start_once_a: assert property (xfer_start |=> !xfer_start)
        else $error("start pulse longer than one cycle");
    select_steady_a: assert property (
        xfer_active && !xfer_start && $past(xfer_active)
        |-> $stable(target_select_n) || target_select_n == 4'hf)
        else $error("select lines moved during transfer");
    // A start inside the release gap would shorten the idle time the target sees
    release_gap_a: assert property (
        target_select_n == 4'hf && $past(target_select_n) != 4'hf
        |=> !xfer_start [*4])
        else $error("start inside release gap");

    // Register bus answers; the write is issued in the cycle both halves are first held
    write_resp_a: assert property (
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
        && !axi_rsp.bvalid |=> ##1 axi_rsp.bvalid)
        else $error("write response late");
    bresp_stand_a: assert property (
        axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write response dropped");
    read_lat_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read data late");
    read_decerr_a: assert property (
        axi_req.arvalid && axi_rsp.arready
        && !(axi_req.araddr inside {`STS_OFF_CTRL, `STS_OFF_LEN, `STS_OFF_STAT})
        |=> axi_rsp.rresp == `STS_RESP_DECERR && axi_rsp.rdata == 32'h0)
        else $error("unmapped read not refused");
    rdata_stand_a: assert property (
        axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data dropped");
endmodule : sts_sel_checker

bind sts_select_ctrl sts_sel_checker chk_i (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .link_sclk(link_sclk), .target_select_n(target_select_n),
    .target_select_oe(target_select_oe), .xfer_start(xfer_start), .xfer_active(xfer_active));

`default_nettype wire

// ---- test/sts_target_model.sv ----
`default_nettype none

module sts_target_model (
    input  wire logic [3:0] target_select_n,
    input  wire logic       target_select_oe,
    output logic            link_sclk,
    output int              edges
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] sel_wire;

    // Undriven selects float to the pull-up level, so no target sees itself picked
    assign sel_wire = target_select_oe ? target_select_n : 4'hf;

    // Each new select pattern gets one frame of the reset length, 8 bits, then the
    // clock rests low, also while selects are held; odd offsets keep its rising edges off aclk edges
    initial begin
        link_sclk = 1'b0;
        edges = 0;
        forever begin
            @(sel_wire);
            if (sel_wire != 4'hf) begin
                repeat (8) begin
                    #83 link_sclk = 1'b1;
                    edges++;
                    #77 link_sclk = 1'b0;
                end
            end
        end
    end
endmodule : sts_target_model

`default_nettype wire

// ---- test/sts_select_ctrl_tb_top.sv ----
`include "sts_consts.svh"
`default_nettype none

module sts_select_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sts_pkg::*;

    logic          aclk;
    logic          aresetn;
    logic          link_sclk;
    sts_axil_req_t req;
    sts_axil_rsp_t rsp;
    logic [3:0]    sel_n;
    logic [3:0]    last_sel;
    logic          oe;
    logic          xs;
    logic          xa;
    logic [31:0]   rdat;
    logic [1:0]    resp;
    int            fails = 0;
    int            n_tests = 0;
    int            starts = 0;
    int            high_cyc = 0;
    int            edges;
    int            s0;
    int            e0;
    logic [3:0]    masks [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'hf};

    sts_select_ctrl dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .link_sclk(link_sclk), .target_select_n(sel_n), .target_select_oe(oe),
        .xfer_start(xs), .xfer_active(xa));
    sts_target_model tgt (.target_select_n(sel_n), .target_select_oe(oe),
        .link_sclk(link_sclk), .edges(edges));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // Counts launches and released cycles, latching the lines seen at each launch
    always @(posedge aclk) begin
        if (xs === 1'b1) begin
            starts <= starts + 1;
            last_sel <= sel_n;
        end
        if (sel_n === 4'hf) high_cyc <= high_cyc + 1;
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready === 1'b1) begin
                aw_ok = 1'b1;
                req.awvalid <= 1'b0;
            end
            if (req.wvalid && rsp.wready === 1'b1) begin
                w_ok = 1'b1;
                req.wvalid <= 1'b0;
            end
        end
        req.bready <= 1'b1;
        do @(posedge aclk); while (rsp.bvalid !== 1'b1);
        resp = rsp.bresp;
        req.bready <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        do @(posedge aclk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        req.rready <= 1'b1;
        do @(posedge aclk); while (rsp.rvalid !== 1'b1);
        rdat = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
    endtask : rd

    // Polls status until neither busy, held nor in the release gap
    task wait_idle;
        for (int i = 0; i < 60; i++) begin
            rd(`STS_OFF_STAT);
            if (rdat[2:0] === 3'b000) break;
        end
    endtask : wait_idle

    task wait_done;
        for (int i = 0; i < 200 && xa !== 1'b0; i++) @(posedge aclk);
    endtask : wait_done

    task t_reset;
        rd(`STS_OFF_CTRL);
        chk("ctrl reset", 32'h0, rdat);
        chk("sel reset", 32'hf, {28'h0, sel_n});
        chk("oe reset", 32'h0, {31'h0, oe});
        rd(`STS_OFF_LEN);
        chk("len reset", {26'h0, `STS_LEN_RST}, rdat);
    endtask : t_reset

    task t_fields;
        wr(`STS_OFF_CTRL, 32'hffffffdf);
        rd(`STS_OFF_CTRL);
        chk("ctrl fields", 32'h000f0113, rdat);
        chk("oe input dir", 32'h0, {31'h0, oe});
        wr(`STS_OFF_CTRL, 32'h00000003);
        chk("oe controller", 32'h1, {31'h0, oe});
        wr(`STS_OFF_CTRL, 32'h00000000);
        chk("oe off", 32'h0, {31'h0, oe});
    endtask : t_fields

    task t_target_mode;
        s0 = starts;
        wr(`STS_OFF_CTRL, 32'h000f0021);
        repeat (8) @(posedge aclk);
        chk("target no start", s0, starts);
        chk("target sel", 32'hf, {28'h0, sel_n});
    endtask : t_target_mode

    task t_masks;
        for (int i = 0; i < 6; i++) begin
            s0 = starts;
            e0 = edges;
            wr(`STS_OFF_CTRL, {12'h0, masks[i], 16'h0023});
            @(posedge aclk);
            chk("one launch", s0 + 1, starts);
            chk("busy at start", 32'h1, {31'h0, xa});
            chk("sel at start", {28'h0, ~masks[i]}, {28'h0, last_sel});
            wait_idle();
            chk("sel released", 32'hf, {28'h0, sel_n});
            chk("link bits", 8, edges - e0);
        end
    endtask : t_masks

    task t_refused;
        s0 = starts;
        wr(`STS_OFF_CTRL, 32'h00010023);
        wr(`STS_OFF_CTRL, 32'h00020023);
        @(posedge aclk);
        chk("busy start dropped", s0 + 1, starts);
        chk("sel kept", 32'he, {28'h0, sel_n});
        wait_idle();
    endtask : t_refused

    task t_hold;
        wr(`STS_OFF_CTRL, 32'h00050123);
        @(posedge aclk);
        wait_done();
        repeat (10) @(posedge aclk);
        chk("sel held", 32'ha, {28'h0, sel_n});
        s0 = starts;
        e0 = high_cyc;
        wr(`STS_OFF_CTRL, 32'h00030123);
        @(posedge aclk);
        chk("held launch", s0 + 1, starts);
        chk("held new sel", 32'hc, {28'h0, last_sel});
        wait_done();
        chk("no release gap", e0, high_cyc);
        wr(`STS_OFF_CTRL, 32'h00000003);
        wait_idle();
        chk("hold cleared", 32'hf, {28'h0, sel_n});
    endtask : t_hold

    task t_unmapped;
        rd(8'h08);
        chk("unmapped rdata", 32'h0, rdat);
        chk("unmapped rresp", `STS_RESP_DECERR, resp);
        wr(8'h08, 32'hffffffff);
        chk("unmapped bresp", `STS_RESP_DECERR, resp);
    endtask : t_unmapped

    task summarize;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    initial begin
        req = '0;
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_fields();
        t_target_mode();
        t_masks();
        t_refused();
        t_hold();
        t_unmapped();
        summarize();
    end

    // Whole run needs under a thousand cycles; this cuts a hang short
    initial begin
        #200us;
        fails++;
        summarize();
    end
endmodule : sts_select_ctrl_tb_top

`default_nettype wire
